/* File: src/gate_control_regs.svh */
// Timing constants and fixed values for the half-bridge gate control block
`ifndef GATE_CONTROL_REGS_SVH
`define GATE_CONTROL_REGS_SVH

// ***********************************************************************
// Time base
// ***********************************************************************
`define CLOCK_PERIOD_NS 10
// Quiet time on the low-side input before standby, in microseconds
`define STANDBY_TIMEOUT_US 90
// Longest time: rounds down
`define STANDBY_TIMEOUT_CYCLES ((`STANDBY_TIMEOUT_US * 1000) / `CLOCK_PERIOD_NS)
// Wake-up delay out of standby, in nanoseconds
`define WAKE_DELAY_NS 490
// Least time: rounds up
`define WAKE_DELAY_CYCLES ((`WAKE_DELAY_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define TIMEOUT_COUNT_WIDTH 14
`define WAKE_COUNT_WIDTH 6

`endif

/* File: src/gate_control_pkg.sv */
// Types shared by the half-bridge gate control design
package gate_control_pkg;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_STANDBY = 2'b01,
    MODE_WAKING = 2'b10
  } power_mode_t;

endpackage

/* File: src/bootstrap_uv_monitor.sv */
// Bootstrap under-voltage latch with hysteresis for the high-side enable
module bootstrap_uv_monitor (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic below_falling_i,
  input wire logic above_rising_i,
  output logic high_side_enable_o
);

  logic uv_latched;
  logic next_uv_latched;

  // Falling crossing wins so a sagging rail never leaves the switch on
  always_comb begin
    next_uv_latched = uv_latched;
    if (below_falling_i) begin
      next_uv_latched = 1'b1;
    end else if (above_rising_i) begin
      next_uv_latched = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      uv_latched <= 1'b1;
    end else begin
      uv_latched <= next_uv_latched;
    end
  end

  assign high_side_enable_o = ~uv_latched & ~below_falling_i;

  uv_hold_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    uv_latched && !above_rising_i |=> !high_side_enable_o)
    else $error("high side enabled before bootstrap recovered");

endmodule

/* File: src/half_bridge_gate_control.sv */
// Gate control logic of a half-bridge power stage
`include "gate_control_regs.svh"

module half_bridge_gate_control (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic low_drive_i,
  input wire logic high_drive_i,
  input wire logic standby_enable_n_i,
  input wire logic supply_lockout_i,
  input wire logic bootstrap_below_falling_i,
  input wire logic bootstrap_above_rising_i,
  output logic low_gate_o,
  output logic high_gate_o,
  output logic bootstrap_switch_o,
  output logic standby_o
);

  // ***********************************************************************
  // Mode and timers
  // ***********************************************************************
  localparam logic [`TIMEOUT_COUNT_WIDTH-1:0] TIMEOUT_LAST =
    `TIMEOUT_COUNT_WIDTH'(`STANDBY_TIMEOUT_CYCLES - 1);
  localparam logic [`WAKE_COUNT_WIDTH-1:0] WAKE_LAST =
    `WAKE_COUNT_WIDTH'(`WAKE_DELAY_CYCLES - 1);

  gate_control_pkg::power_mode_t mode;
  gate_control_pkg::power_mode_t next_mode;
  logic [`TIMEOUT_COUNT_WIDTH-1:0] quiet_count;
  logic [`TIMEOUT_COUNT_WIDTH-1:0] next_quiet_count;
  logic [`WAKE_COUNT_WIDTH-1:0] wake_count;
  logic [`WAKE_COUNT_WIDTH-1:0] next_wake_count;
  logic low_drive_prev;
  logic next_low_drive_prev;
  logic auto_standby_on;
  logic low_rise;
  logic high_side_enable;

  assign auto_standby_on = ~standby_enable_n_i;
  assign low_rise = low_drive_i & ~low_drive_prev;

  always_comb begin
    next_mode = mode;
    next_quiet_count = quiet_count;
    next_wake_count = wake_count;
    next_low_drive_prev = low_drive_i;
    if (supply_lockout_i) begin
      // Lockout parks everything so leaving it starts from a clean count
      next_mode = gate_control_pkg::MODE_NORMAL;
      next_quiet_count = '0;
      next_wake_count = '0;
      next_low_drive_prev = 1'b0;
    end else begin
      unique case (mode)
        gate_control_pkg::MODE_NORMAL: begin
          if (!auto_standby_on || low_drive_i) begin
            next_quiet_count = '0;
          end else if (quiet_count == TIMEOUT_LAST) begin
            next_mode = gate_control_pkg::MODE_STANDBY;
            next_quiet_count = '0;
          end else begin
            next_quiet_count = quiet_count + 1'b1;
          end
        end
        gate_control_pkg::MODE_STANDBY: begin
          if (low_rise) begin
            next_mode = gate_control_pkg::MODE_WAKING;
            next_wake_count = '0;
          end
        end
        gate_control_pkg::MODE_WAKING: begin
          if (wake_count == WAKE_LAST) begin
            next_mode = gate_control_pkg::MODE_NORMAL;
            next_wake_count = '0;
          end else begin
            next_wake_count = wake_count + 1'b1;
          end
        end
        default: begin
          next_mode = gate_control_pkg::MODE_NORMAL;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      mode <= gate_control_pkg::MODE_NORMAL;
      quiet_count <= '0;
      wake_count <= '0;
      low_drive_prev <= 1'b0;
    end else begin
      mode <= next_mode;
      quiet_count <= next_quiet_count;
      wake_count <= next_wake_count;
      low_drive_prev <= next_low_drive_prev;
    end
  end

  // ***********************************************************************
  // Bootstrap supervision
  // ***********************************************************************
  bootstrap_uv_monitor uv_monitor (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .below_falling_i(bootstrap_below_falling_i),
    .above_rising_i(bootstrap_above_rising_i),
    .high_side_enable_o(high_side_enable)
  );

  // ***********************************************************************
  // Gate outputs
  // ***********************************************************************
  logic drive_allowed;
  logic next_low_gate;
  logic next_high_gate;
  logic next_bootstrap;

  assign drive_allowed = ~supply_lockout_i && (next_mode == gate_control_pkg::MODE_NORMAL);

  // Both-high is treated as a controller fault; neither side is favoured
  always_comb begin
    next_low_gate = 1'b0;
    next_high_gate = 1'b0;
    next_bootstrap = 1'b0;
    if (drive_allowed && !(low_drive_i && high_drive_i)) begin
      next_low_gate = low_drive_i;
      next_high_gate = high_drive_i && high_side_enable;
      next_bootstrap = low_drive_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      low_gate_o <= 1'b0;
      high_gate_o <= 1'b0;
      bootstrap_switch_o <= 1'b0;
      standby_o <= 1'b0;
    end else begin
      low_gate_o <= next_low_gate;
      high_gate_o <= next_high_gate;
      bootstrap_switch_o <= next_bootstrap;
      standby_o <= (next_mode != gate_control_pkg::MODE_NORMAL);
    end
  end

  // ***********************************************************************
  // Checks
  // ***********************************************************************
  sequence quiet_low_s;
    !low_drive_i && auto_standby_on && !supply_lockout_i;
  endsequence

  sequence single_low_s;
    low_drive_i && !high_drive_i && !supply_lockout_i && mode == gate_control_pkg::MODE_NORMAL;
  endsequence

  no_shoot_through_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !(low_gate_o && high_gate_o))
    else $error("both power switches on");

  low_follow_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    single_low_s ##0 (next_mode == gate_control_pkg::MODE_NORMAL) |=> low_gate_o)
    else $error("low gate did not follow input");

  high_follow_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !high_drive_i |=> !high_gate_o)
    else $error("high gate on with input low");

  bootstrap_pair_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    bootstrap_switch_o |-> low_gate_o && $past(low_drive_i))
    else $error("bootstrap on without low side");

  lockout_off_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    supply_lockout_i |=> !low_gate_o && !high_gate_o && !bootstrap_switch_o)
    else $error("gates on during lockout");

  timeout_entry_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    quiet_count == TIMEOUT_LAST && mode == gate_control_pkg::MODE_NORMAL ##0 quiet_low_s
    |=> mode == gate_control_pkg::MODE_STANDBY ##0 standby_o)
    else $error("standby not entered at timeout");

  standby_off_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    mode != gate_control_pkg::MODE_NORMAL |-> !low_gate_o && !high_gate_o)
    else $error("gates on in standby");

  // Lockout legally cuts the wake delay short, so it cancels the check
  wake_delay_a: assert property (@(posedge clock_i) disable iff (sys_rst_i || supply_lockout_i)
    mode == gate_control_pkg::MODE_STANDBY && low_rise && !supply_lockout_i
    |=> (mode == gate_control_pkg::MODE_WAKING) [*8])
    else $error("wake delay cut short");

  both_high_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    low_drive_i && high_drive_i |=> !low_gate_o && !high_gate_o)
    else $error("a switch on with both inputs high");

  timeout_restart_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    low_drive_i || standby_enable_n_i |=> quiet_count == '0)
    else $error("timeout not restarted");

endmodule

/* File: tb/pwm_controller_model.sv */
// Model of the outside controller that drives the two gate inputs
module pwm_controller_model (
  input wire logic clock_i,
  input wire logic run_i,
  output logic low_drive_o,
  output logic high_drive_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // ********************************************************
  // Complementary phases, one dead cycle between them
  // ********************************************************
  logic [2:0] phase = 3'h0;

  initial begin
    low_drive_o = 1'h0;
    high_drive_o = 1'h0;
  end

  // Outputs move just after the edge so the block never sees a half change
  always @(posedge clock_i) begin
    phase <= #1 run_i ? phase + 3'h1 : 3'h0;
    low_drive_o <= #1 run_i && phase < 3'h3;
    high_drive_o <= #1 run_i && phase > 3'h3 && phase < 3'h7;
  end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench of the half-bridge gate control block
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ********************************************************
  // Stimulus, block and controller model
  // ********************************************************
  logic clock_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic tb_low = 1'h0;
  logic tb_high = 1'h0;
  logic use_pwm = 1'h0;
  logic standby_enable_n_i = 1'h1;
  logic supply_lockout_i = 1'h0;
  logic below_i = 1'h0;
  logic above_i = 1'h0;
  logic pwm_low, pwm_high, low_drive_i, high_drive_i;
  logic low_gate_o, high_gate_o, bootstrap_switch_o, standby_o;
  int n_fail = 0;
  int compares = 0;

  always #5 clock_i = ~clock_i;
  assign low_drive_i = use_pwm ? pwm_low : tb_low;
  assign high_drive_i = use_pwm ? pwm_high : tb_high;

  half_bridge_gate_control u_dut (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .low_drive_i(low_drive_i),
    .high_drive_i(high_drive_i),
    .standby_enable_n_i(standby_enable_n_i),
    .supply_lockout_i(supply_lockout_i),
    .bootstrap_below_falling_i(below_i),
    .bootstrap_above_rising_i(above_i),
    .low_gate_o(low_gate_o),
    .high_gate_o(high_gate_o),
    .bootstrap_switch_o(bootstrap_switch_o),
    .standby_o(standby_o)
  );

  pwm_controller_model u_pwm (
    .clock_i(clock_i),
    .run_i(use_pwm),
    .low_drive_o(pwm_low),
    .high_drive_o(pwm_high)
  );

  // ********************************************************
  // Shared tasks
  // ********************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic drive(input logic l, input logic h, input int n);
    tb_low = l;
    tb_high = h;
    cyc(n);
  endtask

  // Output vector order: low gate, high gate, bootstrap, standby
  task automatic chk(input logic [3:0] exp);
    logic [3:0] got;
    got = {low_gate_o, high_gate_o, bootstrap_switch_o, standby_o};
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ********************************************************
  // Scenarios
  // ********************************************************
  task automatic t_uv;
    drive(1'h0, 1'h1, 3);
    chk(4'h0);
    above_i = 1'h1;
    cyc(1);
    above_i = 1'h0;
    cyc(3);
    chk(4'h4);
    below_i = 1'h1;
    cyc(2);
    chk(4'h0);
    below_i = 1'h0;
    cyc(3);
    chk(4'h0);
    above_i = 1'h1;
    cyc(3);
    above_i = 1'h0;
    chk(4'h4);
  endtask

  task automatic t_drive;
    drive(1'h1, 1'h0, 2);
    chk(4'ha);
    drive(1'h1, 1'h1, 2);
    chk(4'h0);
    drive(1'h0, 1'h0, 2);
    chk(4'h0);
  endtask

  // Back-to-back phases from the controller model, one cycle latency
  task automatic t_pwm;
    logic l, h;
    use_pwm = 1'h1;
    repeat (48) begin
      @(negedge clock_i);
      l = low_drive_i;
      h = high_drive_i;
      @(posedge clock_i);
      #1;
      chk({l, h, l, 1'h0});
    end
    use_pwm = 1'h0;
  endtask

  task automatic t_lockout;
    drive(1'h1, 1'h0, 2);
    supply_lockout_i = 1'h1;
    cyc(2);
    chk(4'h0);
    supply_lockout_i = 1'h0;
    cyc(2);
    chk(4'ha);
  endtask

  task automatic t_standby;
    drive(1'h0, 1'h0, 9100);
    chk(4'h0);
    standby_enable_n_i = 1'h0;
    drive(1'h0, 1'h0, 8000);
    drive(1'h1, 1'h0, 1);
    drive(1'h0, 1'h0, 8999);
    chk(4'h0);
    cyc(1);
    chk(4'h1);
    drive(1'h0, 1'h1, 3);
    chk(4'h1);
    drive(1'h0, 1'h0, 1);
    drive(1'h1, 1'h0, 49);
    chk(4'h1);
    cyc(1);
    chk(4'ha);
  endtask

  // Lockout out of standby restarts in normal mode with no wake delay
  task automatic t_standby_lockout;
    drive(1'h0, 1'h0, 9000);
    chk(4'h1);
    supply_lockout_i = 1'h1;
    cyc(1);
    chk(4'h0);
    supply_lockout_i = 1'h0;
    drive(1'h1, 1'h0, 1);
    chk(4'ha);
  endtask

  initial begin
    cyc(16);
    sys_rst_i = 1'h0;
    t_uv();
    t_drive();
    t_pwm();
    t_lockout();
    t_standby();
    t_standby_lockout();
    conclude();
  end

  // About twice the expected run length
  initial begin
    #800000;
    n_fail++;
    conclude();
  end
endmodule
